// file: hdl/hxe_ctrl.sv
// Hart width, memory-privilege and endianness control with an APB register port.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
module hxe_ctrl
   import hxe_pkg::*;
#(
   parameter bit BASE64 = 1'b1,
   parameter bit S_MODE = 1'b1,
   parameter bit U_MODE = 1'b1,
   parameter bit PAGING = 1'b1,
   parameter bit SXL_HARD = 1'b0,
   parameter bit UXL_HARD = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trap_enter,
   input wire logic machine_trap_return_pulse,
   input wire logic supervisor_trap_return_pulse,
   input wire logic supervisor_trap_return_to_s,
   input wire logic paging_on,
   input wire logic [63:0] src_operand,
   input wire logic [63:0] alu_result,
   input wire logic [63:0] pc_next,
   input wire logic [63:0] ls_addr,
   output logic [63:0] operand_ext,
   output logic [63:0] result_ext,
   output logic [63:0] pc_ext,
   output logic [63:0] addr_ext,
   output logic [1:0] fetch_priv,
   output logic [1:0] data_priv,
   output logic exec_width32,
   output logic data_width32,
   output logic fetch_big_endian,
   output logic data_big_endian,
   output logic ptw_big_endian,
   output logic mxr_effective,
   output logic sum_effective
);
   // ==========================================================
   // Static values derived from the configuration
   localparam logic [1:0] LEAST_PRV = U_MODE ? PRV_U : PRV_M;
   localparam logic [1:0] RST_MXL = BASE64 ? WID_64 : WID_32;
   localparam logic [1:0] RST_SXL = (BASE64 && S_MODE) ? WID_64 : WID_NONE;
   localparam logic [1:0] RST_UXL = (BASE64 && U_MODE) ? WID_64 : WID_NONE;

   hxe_state_s state_q;
   hxe_state_s state_d;
   logic [1:0] sxl_view;
   logic [1:0] uxl_view;
   logic [1:0] sxl_wr;
   logic [1:0] uxl_wr;
   logic [31:0] ctrl_view;
   logic [31:0] stat_view;
   logic [31:0] wr_word;
   logic mapped;
   logic acc_wr;

   // ==========================================================
   // Decoding helpers
   function automatic logic prv_ok(input logic [1:0] p);
      prv_ok = (p == PRV_M) || (p == PRV_S && S_MODE) || (p == PRV_U && U_MODE);
   endfunction

   // Lower modes are not checked against higher ones; each simply uses its own code.
   function automatic logic is_w32(input logic [1:0] p, input logic [1:0] m,
                                   input logic [1:0] s, input logic [1:0] u);
      if (!BASE64) begin
         is_w32 = 1'b1;
      end else begin
         case (p)
            PRV_M: is_w32 = (m == WID_32);
            PRV_S: is_w32 = (s == WID_32);
            default: is_w32 = (u == WID_32);
         endcase
      end
   endfunction

   function automatic logic be_of(input logic [1:0] p, input hxe_state_s s);
      case (p)
         PRV_M: be_of = s.machine_big_endian_bit;
         PRV_S: be_of = s.supervisor_big_endian_bit;
         default: be_of = s.user_big_endian_bit;
      endcase
   endfunction

   // ==========================================================
   // Visible width fields
   always_comb begin
      if (!BASE64 || !S_MODE) begin
         sxl_view = WID_NONE;
      end else if (SXL_HARD) begin
         sxl_view = state_q.machine_width_field;
      end else begin
         sxl_view = state_q.supervisor_width_field;
      end
      if (!BASE64 || !U_MODE) begin
         uxl_view = WID_NONE;
      end else if (UXL_HARD) begin
         uxl_view = S_MODE ? sxl_view : state_q.machine_width_field;
      end else begin
         uxl_view = state_q.user_width_field;
      end
   end

   // ==========================================================
   // Effective modes, widths and byte order
   assign fetch_priv = state_q.priv;
   assign data_priv = state_q.privilege_override_bit ? state_q.machine_previous_privilege : state_q.priv;
   assign exec_width32 = is_w32(state_q.priv, state_q.machine_width_field, sxl_view, uxl_view);
   assign data_width32 = is_w32(data_priv, state_q.machine_width_field, sxl_view, uxl_view);
   assign fetch_big_endian = 1'b0;
   assign data_big_endian = be_of(data_priv, state_q);
   assign ptw_big_endian = state_q.supervisor_big_endian_bit;
   // These two only qualify the page-table permission check; physical and
   // attribute faults are raised elsewhere and never see them.
   assign mxr_effective = state_q.exec_readable_bit && paging_on;
   assign sum_effective = state_q.sum && paging_on && data_priv == PRV_S;

   // ==========================================================
   // Narrowing of operands, results, pc and data addresses
   logic [63:0] ch_raw [4];
   logic ch_w32 [4];
   logic [63:0] ch_ext [4];
   assign ch_raw[0] = src_operand;
   assign ch_raw[1] = alu_result;
   assign ch_raw[2] = pc_next;
   assign ch_raw[3] = ls_addr;
   assign ch_w32[0] = exec_width32;
   assign ch_w32[1] = exec_width32;
   assign ch_w32[2] = exec_width32;
   assign ch_w32[3] = data_width32;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         hxe_ext_if #(.W(XW)) ch_if ();
         assign ch_if.raw = ch_raw[gi];
         assign ch_if.w32 = ch_w32[gi];
         assign ch_ext[gi] = ch_if.ext;
         hxe_sext #(.W(XW), .N(NW)) u_sext (
            .ch(ch_if)
         );
      end
   endgenerate
   assign operand_ext = ch_ext[0];
   assign result_ext = ch_ext[1];
   assign pc_ext = ch_ext[2];
   assign addr_ext = ch_ext[3];

   // ==========================================================
   // APB register views
   always_comb begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[F_MBE] = state_q.machine_big_endian_bit;
      ctrl_view[F_SBE] = state_q.supervisor_big_endian_bit;
      ctrl_view[F_UBE] = state_q.user_big_endian_bit;
      ctrl_view[F_PRIVILEGE_OVERRIDE_BIT] = state_q.privilege_override_bit;
      ctrl_view[F_MXR] = state_q.exec_readable_bit;
      ctrl_view[F_SUM] = state_q.sum;
      ctrl_view[F_MPP+:2] = state_q.machine_previous_privilege;
      ctrl_view[F_SXL+:2] = sxl_view;
      ctrl_view[F_UXL+:2] = uxl_view;
      stat_view = {24'h00_0000, ptw_big_endian, data_big_endian, data_width32,
                   exec_width32, data_priv, state_q.priv};
   end

   assign mapped = paddr == ADDR_CTRL || paddr == ADDR_MWIDTH || paddr == ADDR_STATE;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = state_q.rdata;
   assign acc_wr = psel && penable && pwrite && mapped;

   // Byte lanes without a strobe keep the current contents.
   always_comb begin
      wr_word = (paddr == ADDR_MWIDTH) ? {28'h000_0000, 2'h0, state_q.machine_width_field} : ctrl_view;
      for (int b = 0; b < 4; b++) begin
         if (pstrb[b]) begin
            wr_word[8*b+:8] = pwdata[8*b+:8];
         end
      end
   end

   hxe_wlegal u_sxl_legal (
      .wr_code(wr_word[F_SXL+:2]),
      .old_code(state_q.supervisor_width_field),
      .present(BASE64 && S_MODE && !SXL_HARD),
      .new_code(sxl_wr)
   );
   hxe_wlegal u_uxl_legal (
      .wr_code(wr_word[F_UXL+:2]),
      .old_code(state_q.user_width_field),
      .present(BASE64 && U_MODE && !UXL_HARD),
      .new_code(uxl_wr)
   );

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;
      if (psel && !penable) begin
         case (paddr)
            ADDR_CTRL: state_d.rdata = ctrl_view;
            ADDR_MWIDTH: state_d.rdata = {28'h000_0000, 2'h0, state_q.machine_width_field};
            ADDR_STATE: state_d.rdata = stat_view;
            default: state_d.rdata = RST_RDATA;
         endcase
      end
      if (acc_wr && paddr == ADDR_CTRL) begin
         state_d.machine_big_endian_bit = wr_word[F_MBE];
         state_d.supervisor_big_endian_bit = S_MODE && wr_word[F_SBE];
         state_d.user_big_endian_bit = U_MODE && wr_word[F_UBE];
         state_d.privilege_override_bit = U_MODE && wr_word[F_PRIVILEGE_OVERRIDE_BIT];
         state_d.exec_readable_bit = S_MODE && wr_word[F_MXR];
         state_d.sum = S_MODE && PAGING && wr_word[F_SUM];
         if (prv_ok(wr_word[F_MPP+:2])) begin
            state_d.machine_previous_privilege = wr_word[F_MPP+:2];
         end
         state_d.supervisor_width_field = sxl_wr;
         state_d.user_width_field = uxl_wr;
      end
      if (acc_wr && paddr == ADDR_MWIDTH && BASE64) begin
         if (wr_word[1:0] == WID_32 || wr_word[1:0] == WID_64) begin
            state_d.machine_width_field = wr_word[1:0];
            if (state_q.machine_width_field == WID_32 && wr_word[1:0] == WID_64) begin
               // Only a 64-bit width exists above 32, so free fields go there.
               if (S_MODE && !SXL_HARD) begin
                  state_d.supervisor_width_field = WID_64;
               end
               if (U_MODE && !UXL_HARD) begin
                  state_d.user_width_field = WID_64;
               end
            end
         end
      end
      // Hart events are applied last so they win over a same-cycle register write.
      if (trap_enter) begin
         state_d.machine_previous_privilege = state_q.priv;
         state_d.priv = PRV_M;
      end else if (machine_trap_return_pulse) begin
         state_d.priv = state_q.machine_previous_privilege;
         state_d.machine_previous_privilege = LEAST_PRV;
         if (state_q.machine_previous_privilege != PRV_M) begin
            state_d.privilege_override_bit = 1'b0;
         end
      end else if (supervisor_trap_return_pulse) begin
         state_d.priv = supervisor_trap_return_to_s ? PRV_S : PRV_U;
         state_d.privilege_override_bit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q.priv <= PRV_M;
         state_q.machine_previous_privilege <= LEAST_PRV;
         state_q.privilege_override_bit <= RST_BIT;
         state_q.exec_readable_bit <= RST_BIT;
         state_q.sum <= RST_BIT;
         state_q.machine_big_endian_bit <= RST_BIT;
         state_q.supervisor_big_endian_bit <= RST_BIT;
         state_q.user_big_endian_bit <= RST_BIT;
         state_q.machine_width_field <= RST_MXL;
         state_q.supervisor_width_field <= RST_SXL;
         state_q.user_width_field <= RST_UXL;
         state_q.rdata <= RST_RDATA;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fetch_little: assert property (fetch_big_endian == 1'b0)
      else $error("fetch byte order not little");
   a_return_clears: assert property (machine_trap_return_pulse && !trap_enter && state_q.machine_previous_privilege != PRV_M
      |=> !state_q.privilege_override_bit && state_q.priv != PRV_M)
      else $error("return below machine kept override");
   a_override_mode: assert property (state_q.privilege_override_bit |-> data_priv == state_q.machine_previous_privilege
      && data_big_endian == be_of(state_q.machine_previous_privilege, state_q))
      else $error("override does not use previous mode");
   a_narrow_base: assert property (!BASE64 |-> exec_width32 && data_width32)
      else $error("narrow base width not 32");
   a_absent_s_zero: assert property (!S_MODE && psel && !penable && paddr == ADDR_CTRL
      |=> prdata[F_SXL+:2] == WID_NONE && !prdata[F_MXR] && !prdata[F_SBE])
      else $error("supervisor fields not zero");
   a_widen_lower: assert property (BASE64 && S_MODE && !SXL_HARD && acc_wr
      && paddr == ADDR_MWIDTH && pstrb[0] && pwdata[1:0] == WID_64
      && state_q.machine_width_field == WID_32 |=> state_q.supervisor_width_field == WID_64)
      else $error("lower width not widened");
   a_sum_scope: assert property (sum_effective |-> data_priv == PRV_S && paging_on)
      else $error("supervisor user access out of scope");
   a_ptw_order: assert property ($changed(state_q.supervisor_big_endian_bit) |-> ptw_big_endian == state_q.supervisor_big_endian_bit)
      else $error("page walk order not supervisor");
   a_trap_saves: assert property (trap_enter |=> state_q.priv == PRV_M
      && state_q.machine_previous_privilege == $past(state_q.priv))
      else $error("trap did not save previous mode");
   a_prev_legal: assert property (state_q.machine_previous_privilege != 2'h2)
      else $error("previous privilege holds reserved code");
   a_machine_trap_return_target: assert property (machine_trap_return_pulse && !trap_enter
      |=> state_q.priv == $past(state_q.machine_previous_privilege) && state_q.machine_previous_privilege == LEAST_PRV)
      else $error("machine return did not restore previous mode");
   a_addr_narrow: assert property (data_width32 |-> addr_ext[63:32] == {32{addr_ext[31]}})
      else $error("address not sign-extended");
   a_pc_narrow: assert property (exec_width32 |-> pc_ext[63:32] == {32{pc_next[31]}})
      else $error("pc not sign-extended");

   c_override_s: cover property (state_q.privilege_override_bit && state_q.machine_previous_privilege == PRV_S && sum_effective);
   c_machine_trap_return_to_u: cover property (machine_trap_return_pulse ##1 state_q.priv == PRV_U);
   c_widen: cover property (state_q.machine_width_field == WID_32 ##1 state_q.machine_width_field == WID_64);
endmodule

// file: hdl/hxe_ext_if.sv
// Carrier between the control block and one width-narrowing unit.
`timescale 1ns/100ps
interface hxe_ext_if #(parameter int W = 64);
   logic [W-1:0] raw;
   logic w32;
   logic [W-1:0] ext;
   modport src (output raw, output w32, input ext);
   modport unit (input raw, input w32, output ext);
endinterface

// file: hdl/hxe_pkg.sv
// Constants and state layout for the hart width, privilege and endian control block.
package hxe_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_MWIDTH = 12'h004;
   localparam logic [11:0] ADDR_STATE = 12'h008;
   // ==========================================================
   // Control register field positions
   localparam int F_MBE = 0;
   localparam int F_SBE = 1;
   localparam int F_UBE = 2;
   localparam int F_PRIVILEGE_OVERRIDE_BIT = 3;
   localparam int F_MXR = 4;
   localparam int F_SUM = 5;
   localparam int F_MPP = 8;
   localparam int F_SXL = 12;
   localparam int F_UXL = 14;
   // ==========================================================
   // Width codes and privilege encodings
   localparam logic [1:0] WID_NONE = 2'h0;
   localparam logic [1:0] WID_32 = 2'h1;
   localparam logic [1:0] WID_64 = 2'h2;
   localparam logic [1:0] PRV_U = 2'h0;
   localparam logic [1:0] PRV_S = 2'h1;
   localparam logic [1:0] PRV_M = 2'h3;
   localparam int XW = 64;
   localparam int NW = 32;
   // ==========================================================
   // Reset values
   localparam logic RST_BIT = 1'b0;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   typedef struct packed {
      logic [1:0] priv;
      logic [1:0] machine_previous_privilege;
      logic privilege_override_bit;
      logic exec_readable_bit;
      logic sum;
      logic machine_big_endian_bit;
      logic supervisor_big_endian_bit;
      logic user_big_endian_bit;
      logic [1:0] machine_width_field;
      logic [1:0] supervisor_width_field;
      logic [1:0] user_width_field;
      logic [31:0] rdata;
   } hxe_state_s;
endpackage

// file: hdl/hxe_sext.sv
// Narrowing unit: drops bits above the active width and sign-extends to full width.
`timescale 1ns/100ps
module hxe_sext
   import hxe_pkg::*;
#(
   parameter int W = XW,
   parameter int N = NW
) (
   hxe_ext_if.unit ch
);
   always_comb begin
      if (ch.w32) begin
         ch.ext = {{(W - N){ch.raw[N-1]}}, ch.raw[N-1:0]};
      end else begin
         ch.ext = ch.raw;
      end
   end
endmodule

// file: hdl/hxe_wlegal.sv
// Legalizes a software write to a lower-mode width field.
`timescale 1ns/100ps
module hxe_wlegal
   import hxe_pkg::*;
(
   input wire logic [1:0] wr_code,
   input wire logic [1:0] old_code,
   input wire logic present,
   output logic [1:0] new_code
);
   // Unsupported encodings are dropped so a present field always holds a usable width; an absent one reads WID_NONE.
   always_comb begin
      if (!present) begin
         new_code = WID_NONE;
      end else if (wr_code == WID_32 || wr_code == WID_64) begin
         new_code = wr_code;
      end else begin
         new_code = old_code;
      end
   end
endmodule

// file: verif/test_hart_register_width_memprv_endian_ctrl.sv
// Self-checking bench for the hart width, memory-privilege and endian control block.
`timescale 1ns/100ps
module test_hart_register_width_memprv_endian_ctrl;
   import hxe_pkg::*;
   typedef struct packed {
      logic [31:0] wd;
      logic [31:0] rd;
      logic pg;
      logic [1:0] dp;
      logic dbe;
      logic ptw;
      logic exec_readable_bit;
      logic sum;
   } hxe_row_s;
   // ==========================================================
   // Stimulus and observed signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic trap_enter = 1'b0;
   logic machine_trap_return_pulse = 1'b0;
   logic supervisor_trap_return_pulse = 1'b0;
   logic supervisor_trap_return_to_s = 1'b0;
   logic paging_on = 1'b1;
   // The narrowing inputs are held fixed; each has a high half that must be discarded.
   logic [63:0] src_operand = 64'hffff_0000_1234_5678;
   logic [63:0] alu_result = 64'h1234_5678_9abc_def0;
   logic [63:0] pc_next = 64'h0000_0001_8000_0000;
   logic [63:0] ls_addr = 64'h1234_5678_9abc_def0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [63:0] operand_ext;
   logic [63:0] result_ext;
   logic [63:0] pc_ext;
   logic [63:0] addr_ext;
   logic [1:0] fetch_priv;
   logic [1:0] data_priv;
   logic exec_width32;
   logic data_width32;
   logic fetch_big_endian;
   logic data_big_endian;
   logic ptw_big_endian;
   logic mxr_effective;
   logic sum_effective;
   logic [31:0] rd;
   logic er;
   int n_mismatch = 0;
   int checked = 0;
   hxe_row_s rows [13] = '{
      '{32'h0000_a000, 32'h0000_a000, 1'b1, PRV_M, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_a001, 32'h0000_a001, 1'b1, PRV_M, 1'b1, 1'b0, 1'b0, 1'b0},
      '{32'h0000_a002, 32'h0000_a002, 1'b1, PRV_M, 1'b0, 1'b1, 1'b0, 1'b0},
      '{32'h0000_a010, 32'h0000_a010, 1'b1, PRV_M, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h0000_a030, 32'h0000_a030, 1'b0, PRV_M, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_a128, 32'h0000_a128, 1'b1, PRV_S, 1'b0, 1'b0, 1'b0, 1'b1},
      '{32'h0000_a128, 32'h0000_a128, 1'b0, PRV_S, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_a10a, 32'h0000_a10a, 1'b1, PRV_S, 1'b1, 1'b1, 1'b0, 1'b0},
      '{32'h0000_a00c, 32'h0000_a00c, 1'b1, PRV_U, 1'b1, 1'b0, 1'b0, 1'b0},
      '{32'h0000_a308, 32'h0000_a308, 1'b1, PRV_M, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_6000, 32'h0000_6000, 1'b1, PRV_M, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_e000, 32'h0000_6000, 1'b1, PRV_M, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_a200, 32'h0000_a000, 1'b1, PRV_M, 1'b0, 1'b0, 1'b0, 1'b0}
   };

   hxe_ctrl u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trap_enter(trap_enter), .machine_trap_return_pulse(machine_trap_return_pulse),
      .supervisor_trap_return_pulse(supervisor_trap_return_pulse), .supervisor_trap_return_to_s(supervisor_trap_return_to_s), .paging_on(paging_on),
      .src_operand(src_operand), .alu_result(alu_result), .pc_next(pc_next),
      .ls_addr(ls_addr), .operand_ext(operand_ext), .result_ext(result_ext),
      .pc_ext(pc_ext), .addr_ext(addr_ext), .fetch_priv(fetch_priv), .data_priv(data_priv),
      .exec_width32(exec_width32), .data_width32(data_width32),
      .fetch_big_endian(fetch_big_endian), .data_big_endian(data_big_endian),
      .ptw_big_endian(ptw_big_endian), .mxr_effective(mxr_effective),
      .sum_effective(sum_effective)
   );

   always #2 pclk = ~pclk;

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) n_mismatch++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 4'hf, rd, er);
      #1;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000, 4'h0, rd, er);
      chk(rd, exp);
      #1;
   endtask

   // Kind 0 enters a trap, 1 is a machine return, 2 a supervisor return.
   task automatic hart_ev(input int k, input logic to_s);
      @(posedge pclk);
      trap_enter <= (k == 0);
      machine_trap_return_pulse <= (k == 1);
      supervisor_trap_return_pulse <= (k == 2);
      supervisor_trap_return_to_s <= to_s;
      @(posedge pclk);
      trap_enter <= 1'b0;
      machine_trap_return_pulse <= 1'b0;
      supervisor_trap_return_pulse <= 1'b0;
      #1;
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #20000;
      n_mismatch++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(ADDR_CTRL, 32'h0000_a000);
      rd_chk(ADDR_MWIDTH, 32'h0000_0002);
      rd_chk(ADDR_STATE, 32'h0000_000f);
      rd_chk(12'h00c, 32'h0000_0000);
      chk(er, 1'b1);
      wr(ADDR_STATE, 32'h0000_00ff);
      rd_chk(ADDR_STATE, 32'h0000_000f);
      foreach (rows[i]) begin
         @(posedge pclk);
         paging_on <= rows[i].pg;
         wr(ADDR_CTRL, rows[i].wd);
         chk(data_priv, rows[i].dp);
         chk(data_big_endian, rows[i].dbe);
         chk(ptw_big_endian, rows[i].ptw);
         chk(fetch_big_endian, 1'b0);
         chk(mxr_effective, rows[i].exec_readable_bit);
         chk(sum_effective, rows[i].sum);
         rd_chk(ADDR_CTRL, rows[i].rd);
      end
      // Override into a 32-bit user mode while the machine stays 64 bits wide.
      wr(ADDR_CTRL, 32'h0000_6008);
      chk(data_width32, 1'b1);
      chk(exec_width32, 1'b0);
      chk(addr_ext, 64'hffff_ffff_9abc_def0);
      chk(result_ext, alu_result);
      chk(fetch_priv, PRV_M);
      hart_ev(1, 1'b0);
      chk(fetch_priv, PRV_U);
      chk(exec_width32, 1'b1);
      chk(result_ext, 64'hffff_ffff_9abc_def0);
      chk(operand_ext, 64'h0000_0000_1234_5678);
      chk(pc_ext, 64'hffff_ffff_8000_0000);
      rd_chk(ADDR_CTRL, 32'h0000_6000);
      hart_ev(0, 1'b0);
      chk(fetch_priv, PRV_M);
      chk(pc_ext, pc_next);
      wr(ADDR_MWIDTH, 32'h0000_0001);
      chk(exec_width32, 1'b1);
      wr(ADDR_MWIDTH, 32'h0000_0002);
      rd_chk(ADDR_CTRL, 32'h0000_a000);
      rd_chk(ADDR_MWIDTH, 32'h0000_0002);
      // A 64-bit user below a 32-bit supervisor is accepted as written.
      wr(ADDR_CTRL, 32'h0000_9008);
      hart_ev(2, 1'b1);
      chk(fetch_priv, PRV_S);
      chk(exec_width32, 1'b1);
      rd_chk(ADDR_CTRL, 32'h0000_9000);
      hart_ev(0, 1'b0);
      rd_chk(ADDR_CTRL, 32'h0000_9100);
      xfer(ADDR_CTRL, 1'b1, 32'hffff_ff01, 4'h1, rd, er);
      rd_chk(ADDR_CTRL, 32'h0000_9101);
      chk(data_big_endian, 1'b1);
      // A supervisor return can also land in user mode, whose order bit is still clear.
      hart_ev(2, 1'b0);
      chk(fetch_priv, PRV_U);
      chk(exec_width32, 1'b0);
      chk(data_big_endian, 1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(ADDR_CTRL, 32'h0000_a000);
      give_verdict();
   end
endmodule
